/* bench/protection_status_flags_tb.sv */
// Purpose: Self-checking bench for the protection status flags.
// Assumes: Zero wait state slave; inputs change just after edges.
// Notes: Expected words are built from the documented bit layout.
`timescale 1ns/10ps
module protection_status_flags_tb;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, subcmd_stb, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] subcmd_word;
  psf_pkg::psf_ctl_t ctl_in;
  psf_pkg::psf_vc_t vc_alert_trig, vc_alert_en, vc_fault_trig, vc_fault_en;
  psf_pkg::psf_tmp_t tmp_alert_trig, tmp_alert_en;
  int errors, total_checks;

  psf_host psf_host_inst (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  psf_top psf_top_inst (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ctl_in(ctl_in),
    .vc_alert_trig(vc_alert_trig), .vc_alert_en(vc_alert_en),
    .vc_fault_trig(vc_fault_trig), .vc_fault_en(vc_fault_en),
    .tmp_alert_trig(tmp_alert_trig), .tmp_alert_en(tmp_alert_en),
    .subcmd_word(subcmd_word), .subcmd_stb(subcmd_stb), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang();
    errors++;
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    psf_host_inst.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    psf_host_inst.xfer(1'b1, a, d, q);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    ctl_in = '0;
    {vc_alert_trig, vc_alert_en, vc_fault_trig, vc_fault_en} = '0;
    {tmp_alert_trig, tmp_alert_en} = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      ctl_in <= psf_pkg::psf_ctl_t'(i[2:0]);
      @(posedge clk);
      rd(psf_pkg::OFS_CSW, {29'h0, i[2:0]});
    end
    $display("test control flags done");
    for (int j = 0; j < 6; j++) begin
      vc_alert_trig <= psf_pkg::psf_vc_t'(6'h3f);
      vc_alert_en <= psf_pkg::psf_vc_t'(6'h1 << j);
      vc_fault_trig <= psf_pkg::psf_vc_t'(~(6'h1 << j));
      vc_fault_en <= psf_pkg::psf_vc_t'(6'h3f);
      @(posedge clk);
      rd(psf_pkg::OFS_VC_ALERT, {24'h0, 6'h1 << j, 2'h0});
      rd(psf_pkg::OFS_VC_FAULT, {24'h0, ~(6'h1 << j), 2'h0});
    end
    for (int j = 0; j < 7; j++) begin
      tmp_alert_trig <= psf_pkg::psf_tmp_t'(7'h7f);
      tmp_alert_en <= psf_pkg::psf_tmp_t'(7'h1 << j);
      @(posedge clk);
      rd(psf_pkg::OFS_TMP_ALERT, j > 2 ? 32'h1 << (j + 1) : 32'h1 << j);
    end
    $display("test flag words done");
    wr(psf_pkg::OFS_CSW, 32'h1234);
    #1;
    chk({16'h0, subcmd_word}, 32'h1234);
    chk({31'h0, subcmd_stb}, 32'h1);
    @(posedge clk);
    #1;
    chk({31'h0, subcmd_stb}, 32'h0);
    @(posedge clk);
    rd(psf_pkg::OFS_VC_ALERT, 32'h80);
    rd(psf_pkg::OFS_CSW, 32'hffa5);
    rd(psf_pkg::OFS_CSW, 32'h7);
    wr(psf_pkg::OFS_CSW, 32'h55aa);
    rd(psf_pkg::OFS_CSW, 32'hffa5);
    wr(psf_pkg::OFS_SUBCMD, 32'h0bcd);
    rd(psf_pkg::OFS_CSW, 32'h7);
    rd(psf_pkg::OFS_SUBCMD, 32'h0bcd);
    $display("test signature done");
    wr(psf_pkg::OFS_INT_MASK, 32'h1);
    wr(psf_pkg::OFS_INT_STAT, 32'hf);
    rd(psf_pkg::OFS_INT_STAT, 32'h0);
    rd(psf_pkg::OFS_INT_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    vc_alert_trig <= psf_pkg::psf_vc_t'(6'h0);
    @(posedge clk);
    vc_alert_trig <= psf_pkg::psf_vc_t'(6'h3f);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(psf_pkg::OFS_INT_STAT, 32'h1);
    wr(psf_pkg::OFS_INT_MASK, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(psf_pkg::OFS_INT_STAT, 32'h1);
    rd(psf_pkg::OFS_INT_STAT, 32'h0);
    $display("test interrupt done");
    print_verdict();
  end
endmodule // protection_status_flags_tb

/* bench/psf_host.sv */
// Purpose: Host model issuing single word AHB-Lite transfers.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes: Tasks start just after a rising edge and end on one.
`timescale 1ns/10ps
module psf_host (
  // Bus clock and answer
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // A stuck slave must not hang the run, so every wait is bounded.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) protection_status_flags_tb.hang();
  endtask

  // Offset zero is written only by the signature test.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= psf_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
endmodule // psf_host

/* core/psf_pkg.sv */
// Purpose: Shared constants and types for the protection status flags.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes: Offsets are byte addresses of aligned words.
package psf_pkg;
  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] OFS_CSW = 8'h00;
  localparam logic [7:0] OFS_VC_ALERT = 8'h04;
  localparam logic [7:0] OFS_VC_FAULT = 8'h08;
  localparam logic [7:0] OFS_TMP_ALERT = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_SUBCMD = 8'h18;
  localparam logic [15:0] CSW_SIGNATURE = 16'hffa5;
  localparam int CSW_LOWPWR_BIT = 2;
  localparam int CSW_LDEXP_BIT = 1;
  localparam int CSW_LDPU_BIT = 0;
  localparam int TMP_RSVD_BIT = 3;
  // ********************************************************************
  // Interrupt status bits
  // ********************************************************************
  localparam int IRQ_W = 4;
  localparam int IRQ_VC_ALERT = 0;
  localparam int IRQ_VC_FAULT = 1;
  localparam int IRQ_TMP_ALERT = 2;
  localparam int IRQ_SUBCMD = 3;
  // ********************************************************************
  // Bus encodings
  // ********************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic low_power_state_flag;
    logic load_detect_expired_flag;
    logic load_pullup_active_flag;
  } psf_ctl_t;
  typedef struct packed {
    logic short_circuit_discharge;
    logic discharge_overcurrent_tier2;
    logic discharge_overcurrent_tier1;
    logic charge_overcurrent;
    logic cell_overvoltage;
    logic cell_undervoltage;
  } psf_vc_t;
  typedef struct packed {
    logic fet_overtemp;
    logic internal_overtemp;
    logic discharge_overtemp;
    logic charge_overtemp;
    logic internal_undertemp;
    logic discharge_undertemp;
    logic charge_undertemp;
  } psf_tmp_t;
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic sig_pend;
    psf_ctl_t ctl;
    psf_vc_t vc_alert;
    psf_vc_t vc_fault;
    psf_tmp_t tmp_alert;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_mask;
    logic [15:0] subcmd;
    logic subcmd_stb;
    logic irq;
  } psf_state_t;
endpackage

/* core/psf_top.sv */
// Purpose: Control status word and protection flag words behind AHB-Lite.
// Assumes: Status inputs are synchronous to clk; word accesses only.
// Notes: Zero wait states; read data is registered in the address phase.
`timescale 1ns/10ps
module psf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device status levels
  input wire psf_pkg::psf_ctl_t ctl_in,
  // Protection triggers and enables
  input wire psf_pkg::psf_vc_t vc_alert_trig,
  input wire psf_pkg::psf_vc_t vc_alert_en,
  input wire psf_pkg::psf_vc_t vc_fault_trig,
  input wire psf_pkg::psf_vc_t vc_fault_en,
  input wire psf_pkg::psf_tmp_t tmp_alert_trig,
  input wire psf_pkg::psf_tmp_t tmp_alert_en,
  // Subcommand path and interrupt
  output logic [15:0] subcmd_word,
  output logic subcmd_stb,
  output logic irq
);
  psf_pkg::psf_state_t s;
  psf_pkg::psf_state_t n;
  localparam int IRQ_W_L = psf_pkg::IRQ_W;
  logic addr_ph;
  logic [IRQ_W_L-1:0] ev;
  logic [IRQ_W_L-1:0] clr;
  logic [15:0] csw_live;

  // ********************************************************************
  // Read views of the words
  // ********************************************************************
  // Reserved bits of the control status word are padded with zero here.
  assign csw_live = {13'h0000, s.ctl};
  // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored.
  assign addr_ph = hsel && hready &&
                   (htrans == psf_pkg::HTRANS_NONSEQ ||
                    htrans == psf_pkg::HTRANS_SEQ);

  function automatic logic [7:0] vc_word(psf_pkg::psf_vc_t v);
    vc_word = {v, 2'h0};
  endfunction

  function automatic logic [7:0] tmp_word(psf_pkg::psf_tmp_t t);
    tmp_word = {t[6:3], 1'h0, t[2:0]};
  endfunction

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n = s;
    clr = '0;
    n.subcmd_stb = 1'b0;
    n.wr_pend = 1'b0;
    n.ctl = ctl_in;
    n.vc_alert = vc_alert_trig & vc_alert_en;
    n.vc_fault = vc_fault_trig & vc_fault_en;
    n.tmp_alert = tmp_alert_trig & tmp_alert_en;
    ev = '0;
    ev[psf_pkg::IRQ_VC_ALERT] = |(n.vc_alert & ~s.vc_alert);
    ev[psf_pkg::IRQ_VC_FAULT] = |(n.vc_fault & ~s.vc_fault);
    ev[psf_pkg::IRQ_TMP_ALERT] = |(n.tmp_alert & ~s.tmp_alert);
    // Write data phase: the address was latched one cycle earlier.
    if (s.wr_pend) begin
      if (s.wr_addr == psf_pkg::OFS_CSW ||
          s.wr_addr == psf_pkg::OFS_SUBCMD) begin
        n.subcmd = hwdata[15:0];
        n.subcmd_stb = 1'b1;
        ev[psf_pkg::IRQ_SUBCMD] = 1'b1;
      end
      if (s.wr_addr == psf_pkg::OFS_CSW) begin
        n.sig_pend = 1'b1;
      end else if (s.wr_addr == psf_pkg::OFS_INT_STAT) begin
        clr = hwdata[IRQ_W_L-1:0];
      end else if (s.wr_addr == psf_pkg::OFS_INT_MASK) begin
        n.int_mask = hwdata[IRQ_W_L-1:0];
      end
    end
    // Address phase: reads are answered from the next edge on.
    if (addr_ph) begin
      if (hwrite) begin
        n.wr_pend = 1'b1;
        n.wr_addr = haddr[7:0];
      end else begin
        n.hrdata = '0;
        if (haddr[7:0] == psf_pkg::OFS_CSW) begin
          if (n.sig_pend) begin
            n.hrdata[15:0] = psf_pkg::CSW_SIGNATURE;
            n.sig_pend = 1'b0;
          end else begin
            n.hrdata[15:0] = csw_live;
          end
        end else if (haddr[7:0] == psf_pkg::OFS_VC_ALERT) begin
          n.hrdata[7:0] = vc_word(s.vc_alert);
        end else if (haddr[7:0] == psf_pkg::OFS_VC_FAULT) begin
          n.hrdata[7:0] = vc_word(s.vc_fault);
        end else if (haddr[7:0] == psf_pkg::OFS_TMP_ALERT) begin
          n.hrdata[7:0] = tmp_word(s.tmp_alert);
        end else if (haddr[7:0] == psf_pkg::OFS_INT_STAT) begin
          n.hrdata[IRQ_W_L-1:0] = s.int_stat;
        end else if (haddr[7:0] == psf_pkg::OFS_INT_MASK) begin
          n.hrdata[IRQ_W_L-1:0] = s.int_mask;
        end else if (haddr[7:0] == psf_pkg::OFS_SUBCMD) begin
          n.hrdata[15:0] = s.subcmd;
        end
      end
    end
    // A new event beats a write-one-to-clear in the same cycle.
    n.int_stat = (s.int_stat & ~clr) | ev;
    n.irq = |(n.int_stat & n.int_mask);
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign hrdata = s.hrdata;
  assign subcmd_word = s.subcmd;
  assign subcmd_stb = s.subcmd_stb;
  assign irq = s.irq;

  // ********************************************************************
  // Check helpers
  // ********************************************************************
  // The signature checks keep their own note of a pending signature, so
  // they do not lean on the pending bit that they are meant to guard.
  logic sig_exp_r;
  logic sig_exp_nxt;

  always_comb begin
    sig_exp_nxt = sig_exp_r;
    if (addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_CSW) begin
      sig_exp_nxt = 1'b0;
    end else if (addr_ph && hwrite && haddr[7:0] == psf_pkg::OFS_CSW) begin
      sig_exp_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sig_exp_r <= 1'b0;
    end else begin
      sig_exp_r <= sig_exp_nxt;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rd_csw;
    addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_CSW;
  endsequence
  sequence wr_csw;
    addr_ph && hwrite && haddr[7:0] == psf_pkg::OFS_CSW;
  endsequence
  sequence rd_csw_sig;
    rd_csw ##0 sig_exp_r;
  endsequence
  sequence rd_csw_live;
    rd_csw ##0 !sig_exp_r;
  endsequence
  sequence wr_sub;
    addr_ph && hwrite && haddr[7:0] == psf_pkg::OFS_SUBCMD;
  endsequence

  AST_CSW_RSVD_ZERO: assert property (
    rd_csw |=> hrdata[31:16] == 16'h0000 &&
      (hrdata[15:0] == psf_pkg::CSW_SIGNATURE || hrdata[15:3] == '0))
    else $error("Control status word reserved bits not zero.");

  AST_SIG_AFTER_WRITE: assert property (
    rd_csw_sig |=> hrdata[15:0] == psf_pkg::CSW_SIGNATURE)
    else $error("Signature missing on first read after write.");

  AST_SIG_ONCE: assert property (
    rd_csw_live |=> hrdata[15:0] == {13'h0000, $past(ctl_in, 2)})
    else $error("Signature returned more than once.");

  AST_CSW_SUBCMD: assert property (
    wr_csw |=> ##1 subcmd_stb && subcmd_word == $past(hwdata[15:0]))
    else $error("Control status write did not reach subcommand path.");

  AST_SUBCMD_WR: assert property (
    wr_sub |=> ##1 subcmd_stb && subcmd_word == $past(hwdata[15:0]))
    else $error("Subcommand write did not reach subcommand path.");

  // A stray strobe would issue a subcommand that the host never sent.
  AST_STB_CAUSE: assert property (
    subcmd_stb |-> $past(addr_ph && hwrite &&
      (haddr[7:0] == psf_pkg::OFS_CSW ||
       haddr[7:0] == psf_pkg::OFS_SUBCMD), 2))
    else $error("Subcommand strobe without a command write.");

  AST_SUBCMD_EVENT: assert property (
    subcmd_stb |-> s.int_stat[psf_pkg::IRQ_SUBCMD])
    else $error("Subcommand write did not raise its status bit.");

  AST_LOWPWR: assert property (
    rd_csw_live |=> hrdata[psf_pkg::CSW_LOWPWR_BIT] ==
      $past(ctl_in.low_power_state_flag, 2))
    else $error("Low power flag does not follow the device state.");

  AST_LDEXP: assert property (
    rd_csw_live |=> hrdata[psf_pkg::CSW_LDEXP_BIT] ==
      $past(ctl_in.load_detect_expired_flag, 2))
    else $error("Load detect timeout flag wrong.");

  AST_LDPU: assert property (
    rd_csw_live |=> hrdata[psf_pkg::CSW_LDPU_BIT] ==
      $past(ctl_in.load_pullup_active_flag, 2))
    else $error("Load pull-up flag wrong.");

  AST_VC_ALERT: assert property (
    addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_VC_ALERT
      |=> hrdata == {24'h0, $past(vc_alert_trig & vc_alert_en, 2), 2'h0})
    else $error("Voltage and current alert word wrong.");

  AST_VC_FAULT: assert property (
    addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_VC_FAULT
      |=> hrdata == {24'h0, $past(vc_fault_trig & vc_fault_en, 2), 2'h0})
    else $error("Voltage and current fault word wrong.");

  AST_TMP_ALERT: assert property (
    addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_TMP_ALERT
      |=> hrdata[psf_pkg::TMP_RSVD_BIT] == 1'b0 &&
          hrdata[7] == $past(tmp_alert_trig.fet_overtemp &&
                             tmp_alert_en.fet_overtemp, 2) &&
          hrdata[0] == $past(tmp_alert_trig.charge_undertemp &&
                             tmp_alert_en.charge_undertemp, 2))
    else $error("Temperature alert word wrong.");

  AST_IRQ_LEVEL: assert property (
    ##1 irq == |(s.int_stat & s.int_mask))
    else $error("Interrupt output disagrees with status and mask.");

  AST_ZERO_WAIT: assert property (
    hreadyout && !hresp)
    else $error("Slave must answer OKAY with no wait.");

  AST_TMP_FULL: assert property (
    addr_ph && !hwrite && haddr[7:0] == psf_pkg::OFS_TMP_ALERT
      |=> hrdata[31:8] == 24'h00_0000 &&
          hrdata[6] == $past(tmp_alert_trig.internal_overtemp &&
                             tmp_alert_en.internal_overtemp, 2) &&
          hrdata[2] == $past(tmp_alert_trig.internal_undertemp &&
                             tmp_alert_en.internal_undertemp, 2))
    else $error("Temperature alert word misplaced.");

  AST_UNMAPPED_ZERO: assert property (
    addr_ph && !hwrite && haddr[7:0] > psf_pkg::OFS_SUBCMD
      |=> hrdata == 32'h0000_0000)
    else $error("Unmapped offset did not read as zero.");

  // Reset is checked with the disable turned off, since the default one
  // would hide exactly the cycles that matter here.
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    sys_rst |=> hreadyout && !hresp && !irq && !subcmd_stb &&
      hrdata == 32'h0000_0000)
    else $error("Outputs not quiet after reset.");
endmodule // psf_top
